/* rtl/lsd_pkg.sv */
// Shared constants and types of the octal low-side driver serial control
`default_nettype none
package lsd_pkg;
  // Channel count and frame counter width
  localparam int unsigned CHAN_COUNT    = 8;
  localparam int unsigned CNT_W         = 4;
  // System clock period
  localparam int unsigned CLK_PERIOD_NS = 50;
  // Least delay from select rise to fault clearing
  localparam int unsigned FAULT_CLEAR_DELAY_NS     = 75000;
  // Same delay in system clocks, rounded up
  localparam int unsigned FAULT_CLEAR_DELAY_CYCLES =
    (FAULT_CLEAR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TIMER_W       = 12;
  // Reset values
  localparam logic [7:0]  DRIVE_RESET   = 8'h00;
  localparam logic [7:0]  SENSE_RESET   = 8'h00;
  // Control states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_FRAME = 3'h2,
    ST_DELAY = 3'h4
  } ctrl_state_t;
endpackage
`default_nettype wire

/* rtl/lowside_driver_ctrl.sv */
// Serial control, output latch and fault unlatching of an eight-channel low-side driver
`default_nettype none
// Behaviour
// [R1] Reset clears shift register, latch, outputs asynchronously
// [R2] Select rise copies shift register into latch
// [R3] Select fall loads sensed output levels
// [R4] Diagnostic output driven only while select low
// [R5] Diagnostic bit one means output sensed high
// [R6] Command one switches off, zero on
// [R7] Output changes on rising, input sampled falling
// [R8] Eight bits, output 07 first, 00 last
// [R9] Per-channel comparator flags overvoltage fault
// [R10] Fault clears after delay following select rise
// [R11] Controller compares returned bits with sent bits
// [R12] Faulted on-channel has its latch bit cleared
// [R13] Unlimited bits pass through for daisy chains
// [R14] Controller sends eight clocks per chained device
module lowside_driver_ctrl
#(
  parameter int unsigned NB = lsd_pkg::CHAN_COUNT
)(
  // System clock and reset
  input  wire logic          clk_sys,
  input  wire logic          resetn,
  // Serial link pins
  input  wire logic          sclk,
  input  wire logic          cs_n,
  input  wire logic          sdi,
  output logic               sdo,
  output logic               sdo_oe,
  // Output stage: drive and sense
  output logic [NB-1:0]      out_on,
  input  wire logic [NB-1:0] out_level,
  input  wire logic [NB-1:0] out_fault
);
  import lsd_pkg::*;

  // ----------------------------------------
  // Input synchronisers (system domain)
  // ----------------------------------------
  logic          cs_meta;        // First stage, select
  logic          cs_sync;        // Second stage, select
  logic          cs_prev;        // Delayed select for edges
  logic [NB-1:0] level_meta;     // First stage, output levels
  logic [NB-1:0] level_sync;     // Second stage, output levels
  logic [NB-1:0] fault_meta;     // First stage, comparators
  logic [NB-1:0] fault_sync;     // Second stage, comparators
  logic          cs_fall;        // Select went low
  logic          cs_rise;        // Select went high

  // Two-flop synchronisers
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      cs_meta    <= 1'b1;
      cs_sync    <= 1'b1;
      cs_prev    <= 1'b1;
      level_meta <= SENSE_RESET;
      level_sync <= SENSE_RESET;
      fault_meta <= SENSE_RESET;
      fault_sync <= SENSE_RESET;
    end
    else
    begin
      cs_meta    <= cs_n;
      cs_sync    <= cs_meta;
      cs_prev    <= cs_sync;
      level_meta <= out_level;
      level_sync <= level_meta;
      fault_meta <= out_fault;
      fault_sync <= fault_meta;
    end
  end

  // Edge detects on synchronised select
  assign cs_fall = cs_prev & ~cs_sync;
  assign cs_rise = ~cs_prev & cs_sync;

  // ----------------------------------------
  // Link domain: shift register on sclk
  // ----------------------------------------
  logic [NB-1:0]    shift;       // Shifted-in command bits
  logic [NB-1:0]    next_shift;  // Next shift contents
  logic [CNT_W-1:0] fall_cnt;    // Falling edges in this frame
  logic [CNT_W-1:0] next_fall_cnt;
  logic             next_sdo;    // Next diagnostic bit
  logic [2:0]       snap_idx;    // Sense bit for this position
  logic [NB-1:0]    snap;        // Sense snapshot, system domain
  logic             frame_clr_n; // Low outside a frame or in reset

  // Frame counter and output flop end with the frame itself
  assign frame_clr_n = resetn & ~cs_n;

  // Next shift and count values
  always_comb
  begin
    // [R7] Sample on falling
    // [R8] Shift msb first
    // [R13] Pass-through chain
    next_shift = {shift[NB-2:0], sdi};
    next_fall_cnt = fall_cnt;
    if (fall_cnt < CNT_W'(NB))
    begin
      next_fall_cnt = fall_cnt + CNT_W'(1);
    end
  end

  // [R1] Async clear shift
  always_ff @(negedge sclk or negedge resetn)
  begin
    if (!resetn)
      shift <= DRIVE_RESET;
    else
      shift <= next_shift;
  end

  // Falling-edge count, cleared while deselected
  always_ff @(negedge sclk or negedge frame_clr_n)
  begin
    if (!frame_clr_n)
      fall_cnt <= '0;
    else
      fall_cnt <= next_fall_cnt;
  end

  // Diagnostic bit selection
  always_comb
  begin
    snap_idx = 3'(NB - 1) - fall_cnt[2:0];
    // [R3] Sense bits first
    // [R5] High level gives one
    if (fall_cnt < CNT_W'(NB))
      next_sdo = snap[snap_idx];
    // [R13] Then shifted bits
    else
      next_sdo = shift[NB-1];
  end

  // [R7] Update on rising
  always_ff @(posedge sclk or negedge frame_clr_n)
  begin
    if (!frame_clr_n)
      sdo <= 1'b0;
    else
      sdo <= next_sdo;
  end

  // ----------------------------------------
  // System domain: latch, output enable, fault timer
  // ----------------------------------------
  ctrl_state_t        state;       // Control state
  ctrl_state_t        next_state;
  logic [NB-1:0]      next_snap;   // Next sense snapshot
  logic [NB-1:0]      next_out_on; // Next drive state
  logic [NB-1:0]      fault_kill;  // Channels to unlatch
  logic               next_sdo_oe; // Next output enable
  logic [TIMER_W-1:0] timer;       // Fault-clear delay count
  logic [TIMER_W-1:0] next_timer;
  logic               delay_done;  // Fault-clear moment

  assign delay_done = (state == ST_DELAY) &&
                      (timer == TIMER_W'(FAULT_CLEAR_DELAY_CYCLES - 1));

  // Per-channel fault unlatch
  genvar g;
  generate
    for (g = 0; g < NB; g = g + 1)
    begin : g_chan
      // [R9] Comparator fault input
      // [R12] Unlatch faulted on-channel
      assign fault_kill[g] = delay_done & out_on[g] & fault_sync[g];
    end
  endgenerate

  // Next state of the control logic
  always_comb
  begin
    next_state  = state;
    next_snap   = snap;
    next_out_on = out_on;
    next_timer  = timer;
    // [R4] Drive only while selected
    next_sdo_oe = ~cs_sync;
    case (state)
      ST_IDLE:
      begin
        if (cs_fall)
        begin
          // [R3] Capture sense levels
          next_snap  = level_sync;
          next_state = ST_FRAME;
        end
      end
      ST_FRAME:
      begin
        if (cs_rise)
        begin
          // [R2] Latch on select rise
          // [R6] One means off
          next_out_on = ~shift;
          next_timer  = '0;
          next_state  = ST_DELAY;
        end
      end
      ST_DELAY:
      begin
        // [R10] Delayed fault clearing
        next_timer  = timer + TIMER_W'(1);
        next_out_on = out_on & ~fault_kill;
        if (cs_fall)
        begin
          next_snap  = level_sync;
          next_state = ST_FRAME;
        end
        else if (delay_done)
        begin
          next_state = ST_IDLE;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // [R1] Async clear latch
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state  <= ST_IDLE;
      snap   <= SENSE_RESET;
      out_on <= DRIVE_RESET;
      timer  <= '0;
      sdo_oe <= 1'b0;
    end
    else
    begin
      state  <= next_state;
      snap   <= next_snap;
      out_on <= next_out_on;
      timer  <= next_timer;
      sdo_oe <= next_sdo_oe;
    end
  end

endmodule
`default_nettype wire

/* verif/lsd_checker_sva.sv */
// Assertion checker for the low-side driver control
`default_nettype none
module lsd_checker #(parameter int unsigned NB = 8) (
  // Clock, reset and link
  input wire logic          clk_sys,
  input wire logic          resetn,
  input wire logic          cs_n,
  input wire logic          sdo,
  input wire logic          sdo_oe,
  // Output stage
  input wire logic [NB-1:0] out_on,
  input wire logic [NB-1:0] out_fault
);
  timeunit 1ns;
  timeprecision 100ps;
  // Cycles since select went high
  logic [10:0] hi;
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
      hi <= 11'h000;
    else
      hi <= cs_n ? hi + 11'(hi != 11'h7FF) : 11'h000;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  sequence sel_low;
    (!cs_n)[*6];
  endsequence
  sequence sel_high;
    cs_n[*6];
  endsequence
  rst_clear_a: assert property ($rose(resetn) |-> out_on == '0 && !sdo_oe)
    else $error("Reset left state");
  oe_off_a: assert property (sel_high |-> !sdo_oe)
    else $error("Driver on idle");
  oe_on_a: assert property ($fell(cs_n) ##0 sel_low |-> sdo_oe)
    else $error("Driver off");
  sdo_idle_a: assert property (cs_n |-> !sdo)
    else $error("Data not parked");
  hold_sel_a: assert property (sel_low |-> $stable(out_on))
    else $error("Outputs moved");
  off_only_a: assert property (sel_high ##1 cs_n[*2] |-> (out_on & ~$past(out_on)) == '0)
    else $error("Output turned on");
  no_early_a: assert property (hi > 11'd9 && hi < 11'd1495 |-> $stable(out_on))
    else $error("Early clear");
  late_clr_a: assert property (hi == 11'd1520 && out_fault == $past(out_fault, 30)
    |-> (out_on & out_fault) == '0) else $error("Fault not cleared");
endmodule
bind lowside_driver_ctrl lsd_checker #(.NB(NB)) chk (.clk_sys(clk_sys), .resetn(resetn),
  .cs_n(cs_n), .sdo(sdo), .sdo_oe(sdo_oe), .out_on(out_on), .out_fault(out_fault));
`default_nettype wire

/* verif/spi_master.sv */
// Behavioural serial master standing in for the controller
`default_nettype none
module spi_master (
  // Link pins
  output logic     sclk,
  output logic     cs_n,
  output logic     sdi,
  input wire logic sdo
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end
  task automatic frame(input logic [15:0] tx, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    // Start off the system clock edge
    #7 cs_n = 1'b0;
    #300;
    for (int i = n - 1; i >= 0; i--)
    begin
      sdi = tx[i];
      #19 sclk = 1'b1;
      #24 rx = {rx[14:0], sdo};
      sclk = 1'b0;
      #5;
    end
    sdi = ~sdi;
    #300 cs_n = 1'b1;
    #300;
  endtask
endmodule
`default_nettype wire

/* verif/tb.sv */
// Self-checking bench for the low-side driver control
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys;
  logic        resetn;
  logic [7:0]  out_level;
  logic [7:0]  out_fault;
  logic [7:0]  out_on;
  logic [15:0] rx;
  wire logic   sclk;
  wire logic   cs_n;
  wire logic   sdi;
  wire logic   sdo;
  wire logic   sdo_oe;
  wire logic   so_pin;
  int          err_total;
  int          compares;
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  lowside_driver_ctrl #(.NB(8)) DUT (.clk_sys(clk_sys), .resetn(resetn), .sclk(sclk),
    .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .out_on(out_on),
    .out_level(out_level), .out_fault(out_fault));
  // Released pin reads back inverted so that late sampling shows up
  assign so_pin = sdo_oe ? sdo : ~sdo;
  spi_master mst (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(so_pin));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (err_total == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Reset values, then one plain frame
  task automatic t_frame();
    check(out_on, 8'h00);
    check({7'h00, sdo_oe}, 8'h00);
    @(posedge clk_sys) out_level <= 8'hC3;
    mst.frame(16'h005A, 8, rx);
    check(rx[7:0], 8'hC3);
    check(out_on, 8'hA5);
  endtask
  // Pins follow the drive; sixteen-bit frame, first eight bits sent pass through
  task automatic t_chain();
    @(posedge clk_sys) out_level <= ~out_on;
    mst.frame(16'h3C0F, 16, rx);
    check(rx[15:8], 8'h5A);
    check(rx[7:0], 8'h3C);
    check(out_on, 8'hF0);
  endtask
  // Overload on two driven channels and one idle one
  task automatic t_fault();
    @(posedge clk_sys) out_fault <= 8'h91;
    mst.frame(16'h000F, 8, rx);
    repeat (1400) @(posedge clk_sys);
    #5 check(out_on, 8'hF0);
    repeat (200) @(posedge clk_sys);
    #5 check(out_on, 8'h60);
    @(posedge clk_sys) out_fault <= 8'h00;
  endtask
  // Reset mid-run clears at once
  task automatic t_reset();
    @(posedge clk_sys) resetn <= 1'b0;
    #10 check(out_on, 8'h00);
    @(posedge clk_sys) resetn <= 1'b1;
  endtask
  initial
  begin
    err_total = 0;
    compares  = 0;
    resetn    = 1'b0;
    out_level = 8'h00;
    out_fault = 8'h00;
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    t_frame();
    t_chain();
    t_fault();
    t_reset();
    final_report();
  end
  // Watchdog, well past the longest sequence
  initial
  begin
    #400000;
    err_total++;
    final_report();
  end
endmodule
`default_nettype wire
